// ---- flash_ctl_pkg.sv ----
// Package with register map, field layout and array geometry for the flash control block
package flash_ctl_pkg;

    localparam logic [7:0] CTL_ADDR        = 8'hf7;
    localparam logic [7:0] BOOT_BLOCK_PROTECT_ADDR      = 8'hf5;
    localparam logic [7:0] CTL_RESET       = 8'h00;
    localparam logic [7:0] BOOT_BLOCK_PROTECT_RESET     = 8'h01;
    localparam int         BIT_PROG        = 0;
    localparam int         BIT_ERASE       = 1;
    localparam int         BIT_HV          = 3;
    localparam int         BIT_WAIT_HALT   = 4;
    localparam int         ARRAY_AW        = 15;
    localparam int         ROW_BITS        = 6;
    localparam int         BOOT_BITS       = 13;
    localparam logic [1:0] BOOT_TOP        = 2'h3;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
        logic        size_byte;
    } array_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        valid;
    } array_rsp_t;

endpackage : flash_ctl_pkg

// ---- flash_word_cell.sv ----
// One 16-bit word of flash storage: program clears bits, erase sets them
`timescale 1ns/1ps
module flash_word_cell
    import flash_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        prog_en,
    input  wire logic [1:0]  lane_en,
    input  wire logic [15:0] prog_data,
    input  wire logic        erase_en,
    output logic      [15:0] word_q
);
    logic [15:0] keep_mask;

    assign keep_mask = {lane_en[1] ? prog_data[15:8] : ERASED_BYTE,
                        lane_en[0] ? prog_data[7:0]  : ERASED_BYTE};

    always_ff @(posedge clk)
    begin
        if (rst)
            word_q <= {ERASED_BYTE, ERASED_BYTE};
        else if (erase_en)
            word_q <= {ERASED_BYTE, ERASED_BYTE};
        else if (prog_en)
            word_q <= word_q & keep_mask;
    end
endmodule : flash_word_cell

// ---- flash_read_port.sv ----
// Read path: aligned access in one cycle, misaligned word in two
`timescale 1ns/1ps
module flash_read_port
    import flash_ctl_pkg::*;
#(
    parameter int WORDS = 64
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire array_req_t               req,
    input  wire logic [WORDS*16-1:0]      words,
    output array_rsp_t                    rsp
);
    logic        pend_q;
    logic [15:0] pend_addr_q;
    logic [7:0]  pend_lo_q;
    logic        mis;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] nxt;

    function automatic logic [15:0] pick(input logic [WORDS*16-1:0] m, input logic [15:0] a);
        logic [$clog2(WORDS)-1:0] idx;
        idx  = a[$clog2(WORDS):1];
        pick = m[idx*16 +: 16];
    endfunction : pick

    assign mis = req.rd && !req.size_byte && req.addr[0];
    assign nxt = req.addr + 16'h0001;
    assign w0  = pick(words, req.addr);
    assign w1  = pick(words, pend_addr_q);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_q      <= 1'b0;
            pend_addr_q <= 16'h0000;
            pend_lo_q   <= 8'h00;
            rsp         <= '0;
        end
        else
        begin
            pend_q <= mis && !pend_q;
            rsp.valid <= 1'b0;
            if (pend_q)
            begin
                rsp.rdata <= {pend_lo_q, w1[15:8]};
                rsp.valid <= 1'b1;
            end
            else if (mis)
            begin
                pend_addr_q <= nxt;
                pend_lo_q   <= w0[7:0];
            end
            else if (req.rd)
            begin
                rsp.valid <= 1'b1;
                if (req.size_byte)
                    rsp.rdata <= {8'h00, req.addr[0] ? w0[7:0] : w0[15:8]};
                else
                    rsp.rdata <= w0;
            end
        end
    end

    property p_mis_two;
        @(posedge clk) disable iff (rst)
            (mis && !pend_q) |=> !rsp.valid ##1 rsp.valid;
    endproperty
    a_mis_two: assert property (p_mis_two)
        else $error("misaligned read not answered on second cycle");
endmodule : flash_read_port

// ---- flash_program_erase_control.sv ----
// Flash control register, program/erase sequencer and storage of one array
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module flash_program_erase_control
    import flash_ctl_pkg::*;
#(
    parameter int WORDS      = 64,
    parameter int BOOT_WORDS = 16
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire array_req_t  array_req,
    output array_rsp_t       array_rsp,
    input  wire logic        lock_active,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    output logic             flash_clk_en,
    output logic             charge_pump_on,
    output logic             program_pulse,
    output logic             erase_pulse
);
    typedef enum logic [1:0] {IDLE, ARMED, LATCHED} seq_t;

    logic        prog_sel_q;
    logic        erase_sel_q;
    logic        hv_q;
    logic        wait_halt_q;
    logic        boot_prot_q;
    logic        ctl_wr;
    logic        boot_wr;
    logic        abort;
    logic        arr_wr;
    logic        in_boot;
    logic        word_prog;
    logic        boot_sel_wr;
    logic [7:0]  ctl_view;
    logic [7:0]  rdata_q;
    logic [15:0] row_q;
    seq_t        seq_q;
    logic [WORDS*16-1:0] words;
    logic [1:0]  lanes;

    assign ctl_wr  = reg_wr && reg_addr == CTL_ADDR;
    assign boot_wr = reg_wr && reg_addr == BOOT_BLOCK_PROTECT_ADDR;
    assign abort   = stop_mode || wait_mode;
    assign arr_wr  = array_req.wr;

    assign ctl_view = {3'h0, wait_halt_q, hv_q, 1'b0, erase_sel_q, prog_sel_q};

    // Program select and erase select with mutual interlock
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prog_sel_q  <= CTL_RESET[BIT_PROG];
            erase_sel_q <= CTL_RESET[BIT_ERASE];
            wait_halt_q <= CTL_RESET[BIT_WAIT_HALT];
        end
        else if (abort)
        begin
            prog_sel_q  <= 1'b0;
            erase_sel_q <= 1'b0;
        end
        else if (ctl_wr)
        begin
            wait_halt_q <= reg_wdata[BIT_WAIT_HALT];
            if (reg_wdata[BIT_PROG] && reg_wdata[BIT_ERASE])
            begin
                prog_sel_q  <= prog_sel_q;
                erase_sel_q <= erase_sel_q;
            end
            else
            begin
                prog_sel_q  <= reg_wdata[BIT_PROG] && !erase_sel_q;
                erase_sel_q <= reg_wdata[BIT_ERASE] && !prog_sel_q;
            end
        end
    end

    // Row latch sequence: select arms, first array write latches
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seq_q <= IDLE;
            row_q <= 16'h0000;
        end
        else
        begin
            case (seq_q)
                IDLE:
                    if (prog_sel_q || erase_sel_q)
                        seq_q <= ARMED;
                ARMED:
                    if (!(prog_sel_q || erase_sel_q))
                        seq_q <= IDLE;
                    else if (arr_wr)
                    begin
                        seq_q <= LATCHED;
                        row_q <= {array_req.addr[15:ROW_BITS], {ROW_BITS{1'b0}}};
                    end
                LATCHED:
                    if (!(prog_sel_q || erase_sel_q) && !hv_q)
                        seq_q <= IDLE;
                default:
                    seq_q <= IDLE;
            endcase
            if (abort)
                seq_q <= IDLE;
        end
    end

    // High voltage enable
    always_ff @(posedge clk)
    begin
        if (rst)
            hv_q <= CTL_RESET[BIT_HV];
        else if (abort)
            hv_q <= 1'b0;
        else if (ctl_wr)
            hv_q <= reg_wdata[BIT_HV] && (hv_q ||
                    ((prog_sel_q || erase_sel_q) && seq_q == LATCHED));
    end

    // Boot protect, frozen while locked or program enable set
    assign boot_sel_wr = boot_wr && !lock_active && !(prog_sel_q || erase_sel_q);
    always_ff @(posedge clk)
    begin
        if (rst)
            boot_prot_q <= BOOT_BLOCK_PROTECT_RESET[0];
        else if (boot_sel_wr)
            boot_prot_q <= reg_wdata[0];
    end

    // Register read data, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_q <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == CTL_ADDR)
                rdata_q <= ctl_view;
            else if (reg_addr == BOOT_BLOCK_PROTECT_ADDR)
                rdata_q <= {7'h00, boot_prot_q};
            else
                rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    assign flash_clk_en   = !(wait_mode && wait_halt_q);
    assign charge_pump_on = hv_q;

    // Word programming only within the latched row, with high voltage on
    assign in_boot   = array_req.addr[15:BOOT_BITS] == {BOOT_TOP, 1'b1};
    assign word_prog = arr_wr && prog_sel_q && hv_q && seq_q == LATCHED &&
                       array_req.addr[15:ROW_BITS] == row_q[15:ROW_BITS] &&
                       !array_req.addr[0] &&
                       !(boot_prot_q && in_boot) && !abort;
    assign lanes = array_req.size_byte ?
                   (array_req.addr[0] ? 2'h1 : 2'h2) : 2'h3;
    assign program_pulse = word_prog;
    assign erase_pulse   = erase_sel_q && hv_q && seq_q == LATCHED && !abort;

    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++)
        begin : g_word
            logic hit;
            logic ers;
            assign hit = word_prog && !array_req.addr[0] &&
                         array_req.addr[$clog2(WORDS):1] == gi;
            assign ers = erase_pulse &&
                         !(boot_prot_q && gi >= WORDS - BOOT_WORDS);
            flash_word_cell u_cell (
                .clk       (clk),
                .rst       (rst),
                .prog_en   (hit),
                .lane_en   (lanes),
                .prog_data (array_req.wdata),
                .erase_en  (ers),
                .word_q    (words[gi*16 +: 16])
            );
        end
    endgenerate

    flash_read_port #(.WORDS(WORDS)) u_read (
        .clk   (clk),
        .rst   (rst),
        .req   (array_req),
        .words (words),
        .rsp   (array_rsp)
    );

    property p_no_both;
        @(posedge clk) disable iff (rst) !(prog_sel_q && erase_sel_q);
    endproperty
    a_no_both: assert property (p_no_both) else $error("both selects set");

    property p_hv_guard;
        @(posedge clk) disable iff (rst)
            $rose(hv_q) |-> $past(seq_q) == LATCHED;
    endproperty
    a_hv_guard: assert property (p_hv_guard) else $error("hv set early");

    property p_abort;
        @(posedge clk) disable iff (rst)
            abort |=> !hv_q && !prog_sel_q && !erase_sel_q;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");

    property p_clk_halt;
        @(posedge clk) disable iff (rst)
            (wait_mode && wait_halt_q) |-> !flash_clk_en;
    endproperty
    a_clk_halt: assert property (p_clk_halt) else $error("clock not halted");

    property p_rsvd;
        @(posedge clk) disable iff (rst)
            $past(reg_rd) && $past(reg_addr) == CTL_ADDR |-> reg_rdata[7:5] == 3'h0 && !reg_rdata[2];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_idle_wr;
        @(posedge clk) disable iff (rst)
            !prog_sel_q |-> !program_pulse;
    endproperty
    a_idle_wr: assert property (p_idle_wr) else $error("write changed array");

    property p_boot;
        @(posedge clk) disable iff (rst)
            (boot_prot_q && in_boot) |-> !program_pulse;
    endproperty
    a_boot: assert property (p_boot) else $error("boot block programmed");

    property p_boot_block_protect_freeze;
        @(posedge clk) disable iff (rst)
            (lock_active || prog_sel_q) |=> $stable(boot_prot_q);
    endproperty
    a_boot_block_protect_freeze: assert property (p_boot_block_protect_freeze) else $error("boot protect moved");

    property p_clk_run;
        @(posedge clk) disable iff (rst)
            !wait_mode |-> flash_clk_en;
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock halted outside wait");

    property p_halt_wr;
        @(posedge clk) disable iff (rst)
            (ctl_wr && !abort) |=> wait_halt_q == $past(reg_wdata[BIT_WAIT_HALT]);
    endproperty
    a_halt_wr: assert property (p_halt_wr) else $error("wait-halt bit not written");

    property p_hv_sel;
        @(posedge clk) disable iff (rst)
            $rose(hv_q) |-> $past(prog_sel_q || erase_sel_q);
    endproperty
    a_hv_sel: assert property (p_hv_sel) else $error("hv set with no select");

    property p_hv_latched;
        @(posedge clk) disable iff (rst)
            hv_q |-> seq_q == LATCHED;
    endproperty
    a_hv_latched: assert property (p_hv_latched) else $error("hv on outside latched");

    property p_both_hold;
        @(posedge clk) disable iff (rst)
            (ctl_wr && reg_wdata[BIT_PROG] && reg_wdata[BIT_ERASE] && !abort) |=>
                $stable(prog_sel_q) && $stable(erase_sel_q);
    endproperty
    a_both_hold: assert property (p_both_hold) else $error("double select changed");

    property p_rd_ctl;
        @(posedge clk) disable iff (rst)
            (reg_rd && reg_addr == CTL_ADDR) |=> reg_rdata == $past(ctl_view);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

    // Without erase no stored bit may go from zero to one
    property p_no_set;
        @(posedge clk) disable iff (rst)
            !erase_pulse |=> (words & ~$past(words)) == '0;
    endproperty
    a_no_set: assert property (p_no_set) else $error("bit set without erase");

    property p_prog_aligned;
        @(posedge clk) disable iff (rst)
            program_pulse |-> !array_req.addr[0];
    endproperty
    a_prog_aligned: assert property (p_prog_aligned) else $error("misaligned program");

    property p_armed;
        @(posedge clk) disable iff (rst)
            (seq_q == IDLE && (prog_sel_q || erase_sel_q) && !abort) |=> seq_q == ARMED;
    endproperty
    a_armed: assert property (p_armed) else $error("select did not arm latch");

    property p_row_latch;
        @(posedge clk) disable iff (rst)
            (seq_q == ARMED && (prog_sel_q || erase_sel_q) && arr_wr && !abort) |=>
                seq_q == LATCHED && row_q == {$past(array_req.addr[15:ROW_BITS]),
                                              {ROW_BITS{1'b0}}};
    endproperty
    a_row_latch: assert property (p_row_latch) else $error("row not latched");

    property p_erase_all;
        @(posedge clk) disable iff (rst)
            erase_pulse |=> words[15:0] == {ERASED_BYTE, ERASED_BYTE};
    endproperty
    a_erase_all: assert property (p_erase_all) else $error("word not erased");

    property p_boot_spare;
        @(posedge clk) disable iff (rst)
            (erase_pulse && boot_prot_q) |=> $stable(words[WORDS*16-1 -: 16]);
    endproperty
    a_boot_spare: assert property (p_boot_spare) else $error("boot word erased");

    property p_abort_pulse;
        @(posedge clk) disable iff (rst)
            abort |-> !program_pulse && !erase_pulse;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("pulse during abort");

    property p_boot_block_protect_wr;
        @(posedge clk) disable iff (rst)
            (boot_wr && !lock_active && !(prog_sel_q || erase_sel_q)) |=>
                boot_prot_q == $past(reg_wdata[0]);
    endproperty
    a_boot_block_protect_wr: assert property (p_boot_block_protect_wr) else $error("boot protect not written");
endmodule : flash_program_erase_control

// ---- cpu_sw_master.sv ----
// Software-side bus master that walks the flash through its sequences
`timescale 1ns/1ps
module cpu_sw_master
    import flash_ctl_pkg::*;
#(
    parameter int US_CYC   = 20,
    parameter int ERASE_US = 8000
)
(
    input  wire logic  clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd,
    output array_req_t array_req
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        array_req = '0;
    end

    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~d;
    endtask : reg_op

    // Released lines show the inverse so stale values never look valid
    task automatic arr_op(input logic wr, input logic sz8, input logic [15:0] a,
                          input logic [15:0] d);
        @(posedge clk);
        array_req <= '{addr: a, wdata: d, wr: wr, rd: !wr, size_byte: sz8};
        @(posedge clk);
        array_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, size_byte: !sz8};
    endtask : arr_op

    task automatic pause_us(input int n);
        repeat (n * US_CYC) @(posedge clk);
    endtask : pause_us

    task automatic start_prog(input logic [15:0] row);
        reg_op(1'b1, CTL_ADDR, 8'h01);
        arr_op(1'b1, 1'b0, row, 16'h5a5a);
        pause_us(10);
        reg_op(1'b1, CTL_ADDR, 8'h09);
        pause_us(5);
    endtask : start_prog

    task automatic prog_word(input logic [15:0] a, input logic [15:0] d);
        arr_op(1'b1, 1'b0, a, d);
        pause_us(30);
    endtask : prog_word

    task automatic end_prog();
        reg_op(1'b1, CTL_ADDR, 8'h08);
        pause_us(5);
        reg_op(1'b1, CTL_ADDR, 8'h00);
        pause_us(1);
    endtask : end_prog

    task automatic erase_start(input logic [15:0] a);
        reg_op(1'b1, CTL_ADDR, 8'h02);
        arr_op(1'b1, 1'b0, a, 16'h1234);
        pause_us(10);
        reg_op(1'b1, CTL_ADDR, 8'h0a);
    endtask : erase_start

    task automatic erase_end();
        pause_us(ERASE_US);
        reg_op(1'b1, CTL_ADDR, 8'h08);
        pause_us(100);
        reg_op(1'b1, CTL_ADDR, 8'h00);
        pause_us(1);
    endtask : erase_end
endmodule : cpu_sw_master

// ---- flash_program_erase_control_tb.sv ----
// Self-checking bench for the flash control block
`timescale 1ns/1ps
module flash_program_erase_control_tb
    import flash_ctl_pkg::*;
    ;
    typedef struct packed {
        int          due;
        logic [15:0] exp;
        logic [15:0] mask;
    } note_t;

    logic        clk = 1'b0;
    logic        rst;
    logic        lock_active;
    logic        stop_mode;
    logic        wait_mode;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, flash_clk_en, charge_pump_on, program_pulse, erase_pulse;
    array_req_t  array_req;
    array_rsp_t  array_rsp;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          seed = 32'hb0bd;
    logic        pend = 1'b0;
    logic        pp_chk = 1'b0;
    logic        pp_exp = 1'b0;
    logic [7:0]  rq[$];
    note_t       aq[$];
    note_t       n;
    logic [15:0] d1, d2, d3, d4;

    always #25 clk = ~clk;

    flash_program_erase_control flash_program_erase_control_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .array_req(array_req), .array_rsp(array_rsp), .lock_active(lock_active),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .flash_clk_en(flash_clk_en),
        .charge_pump_on(charge_pump_on), .program_pulse(program_pulse),
        .erase_pulse(erase_pulse)
    );

    // Erase hold shortened: the block does not time it
    cpu_sw_master #(.ERASE_US(20)) cpu_sw_master_i (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .array_req(array_req)
    );

    task automatic stop_test();
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        cpu_sw_master_i.reg_op(1'b1, a, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        cpu_sw_master_i.reg_op(1'b0, a, 8'h00);
    endtask : rd_reg

    task automatic rd_arr(input logic sz8, input logic [15:0] a, input logic [15:0] e,
                          input logic [15:0] m);
        aq.push_back('{due: cyc + ((a[0] && !sz8) ? 4 : 3), exp: e, mask: m});
        cpu_sw_master_i.arr_op(1'b0, sz8, a, 16'h0000);
        repeat (2) @(posedge clk);
    endtask : rd_arr

    task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic e);
        pp_chk = 1'b1;
        pp_exp = e;
        cpu_sw_master_i.prog_word(a, d);
        pp_chk = 1'b0;
    endtask : prog

    always @(posedge clk)
    begin
        cyc  <= cyc + 1;
        pend <= reg_rd;
        if (pend)
            check("reg_rdata", {8'h00, reg_rdata}, {8'h00, rq.pop_front()});
        if (array_rsp.valid)
        begin
            n = aq.pop_front();
            check("rsp_cycle", cyc[15:0], n.due[15:0]);
            check("rsp_data", array_rsp.rdata & n.mask, n.exp & n.mask);
        end
        if (array_req.wr && pp_chk)
            check("program_pulse", {15'h0, program_pulse}, {15'h0, pp_exp});
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        rst         <= 1'b1;
        lock_active <= 1'b0;
        stop_mode   <= 1'b0;
        wait_mode   <= 1'b0;
        d1 = 16'($random(seed));
        d2 = 16'($random(seed));
        d3 = 16'($random(seed));
        d4 = 16'($random(seed));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(CTL_ADDR, CTL_RESET);
        rd_reg(BOOT_BLOCK_PROTECT_ADDR, BOOT_BLOCK_PROTECT_RESET);
        rd_reg(8'h10, 8'h00);
        wr_reg(CTL_ADDR, 8'hff);
        rd_reg(CTL_ADDR, 8'h10);
        wait_mode <= 1'b1;
        @(posedge clk);
        check("flash_clk_en", {15'h0, flash_clk_en}, 16'h0000);
        wait_mode <= 1'b0;
        wr_reg(CTL_ADDR, 8'h00);
        wait_mode <= 1'b1;
        @(posedge clk);
        check("flash_clk_en", {15'h0, flash_clk_en}, 16'h0001);
        wait_mode <= 1'b0;
        cpu_sw_master_i.arr_op(1'b1, 1'b0, 16'h0010, d1);
        rd_arr(1'b0, 16'h0010, 16'hffff, 16'hffff);
        wr_reg(CTL_ADDR, 8'h08);
        rd_reg(CTL_ADDR, 8'h00);
        cpu_sw_master_i.start_prog(16'h0000);
        check("charge_pump_on", {15'h0, charge_pump_on}, 16'h0001);
        wr_reg(CTL_ADDR, 8'h0b);
        rd_reg(CTL_ADDR, 8'h09);
        prog(16'h0010, d1, 1'b1);
        prog(16'h0010, d2, 1'b1);
        prog(16'h0012, d3, 1'b1);
        prog(16'h0015, 16'h0000, 1'b0);
        prog(16'h0040, 16'h0000, 1'b0);
        cpu_sw_master_i.end_prog();
        rd_arr(1'b0, 16'h0010, d1 & d2, 16'hffff);
        rd_arr(1'b0, 16'h0011, {d1[7:0] & d2[7:0], d3[15:8]}, 16'hffff);
        rd_arr(1'b1, 16'h0013, {8'h00, d3[7:0]}, 16'h00ff);
        rd_arr(1'b0, 16'h0014, 16'hffff, 16'hffff);
        rd_arr(1'b0, 16'h0040, 16'hffff, 16'hffff);
        lock_active <= 1'b1;
        wr_reg(BOOT_BLOCK_PROTECT_ADDR, 8'h00);
        rd_reg(BOOT_BLOCK_PROTECT_ADDR, 8'h01);
        cpu_sw_master_i.start_prog(16'he000);
        prog(16'he004, 16'h0000, 1'b0);
        cpu_sw_master_i.end_prog();
        rd_arr(1'b0, 16'he004, 16'hffff, 16'hffff);
        lock_active <= 1'b0;
        wr_reg(BOOT_BLOCK_PROTECT_ADDR, 8'h00);
        rd_reg(BOOT_BLOCK_PROTECT_ADDR, 8'h00);
        cpu_sw_master_i.start_prog(16'he000);
        prog(16'he004, d4, 1'b1);
        cpu_sw_master_i.end_prog();
        rd_arr(1'b0, 16'he004, d4, 16'hffff);
        cpu_sw_master_i.erase_start(16'h0022);
        @(negedge clk);
        check("erase_pulse", {15'h0, erase_pulse}, 16'h0001);
        cpu_sw_master_i.erase_end();
        rd_arr(1'b0, 16'h0010, 16'hffff, 16'hffff);
        rd_arr(1'b0, 16'he004, 16'hffff, 16'hffff);
        wr_reg(BOOT_BLOCK_PROTECT_ADDR, 8'h01);
        cpu_sw_master_i.start_prog(16'h0040);
        prog(16'h007e, d4, 1'b1);
        cpu_sw_master_i.end_prog();
        cpu_sw_master_i.erase_start(16'h0000);
        cpu_sw_master_i.erase_end();
        rd_arr(1'b0, 16'h007e, d4, 16'hffff);
        cpu_sw_master_i.start_prog(16'h0000);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk);
        check("charge_pump_on", {15'h0, charge_pump_on}, 16'h0000);
        stop_mode <= 1'b0;
        rd_reg(CTL_ADDR, 8'h00);
        stop_test();
    end
endmodule : flash_program_erase_control_tb
